// file: hw/sbid_defines.svh
`ifndef SBID_DEFINES_SVH
`define SBID_DEFINES_SVH

// transaction type codes on the input bus (7-bit type field)
`define TT_READ 7'h00
`define TT_BYTE_SWAPPED_READ 7'h01
`define TT_READ_SHORT 7'h02
`define TT_WRITE 7'h08
`define TT_WRITE_BACK 7'h09
`define TT_FLUSH_BACK 7'h0A
`define TT_CACHE_TO_CACHE_WRITE 7'h0B
// short write keeps type bit 2 clear so it never reads as coherent
`define TT_WRITE_SHORT 7'h03
`define TT_SHARED_OR_PRIVATE_READ 7'h04
`define TT_READ_CURRENT 7'h05
`define TT_PRIVATE_READ 7'h06
`define TT_CLEAR_PRIVATE 7'h07
`define TT_DATA_FLUSH 7'h14
`define TT_DATA_FLUSH_WR 7'h15
`define TT_DATA_FLUSH_RD 7'h16
`define TT_DATA_FLUSH_RD_WR 7'h17
`define TT_INSTRUCTION_FLUSH 7'h1C
`define TT_DATA_PURGE 7'h24
`define TT_DATA_PURGE_ALLOCATE 7'h25
`define TT_CACHE_SYNC 7'h2C
`define TT_DMA_SYNC 7'h2D
`define TT_COHERENT_BIT 2
`define TT_WIDTH 7
`define DATA_WIDTH 128
`define BYTES 16
`define MAP_INDEX_WIDTH 5
`define GROUP_BYTES 4
// reset reads as no response from every responder
`define COH_RESP_RESET 8'hFF
`define IO_RESP_RESET 2'h3

`endif

// file: hw/sbid_pkg.sv
package sbid_pkg;
    typedef enum logic [1:0] {
        COH_OK = 2'h0,
        COH_COPY_OUT = 2'h1,
        COH_SHARED = 2'h2,
        COH_NO_RESPONSE = 2'h3
    } coherency_resp_t;

    typedef struct packed {
        logic dependent_read;
        logic mem_read;
        logic mem_write;
        logic io_cache_to_cache_write;
        logic io_read;
        logic io_write;
        logic flush;
        logic purge;
        logic purge_alloc;
        logic sync;
        logic coherent;
        logic byte_swap;
        logic zero_length;
        logic private_read;
    } strobes_t;
endpackage : sbid_pkg

// file: hw/sbid_if.sv
`timescale 1ns/10ps
`include "sbid_defines.svh"
interface sbid_if;
    logic [`DATA_WIDTH-1:0] addr_data;
    logic [`BYTES-1:0] byte_parity;
    logic [1:0] data_error;
    logic error;
    sbid_pkg::strobes_t strobes;
    logic [7:0] cpu_coherency_resp;
    logic [1:0] io_coherency_resp;
    logic [`MAP_INDEX_WIDTH-1:0] next_read_map_index;
    logic [`MAP_INDEX_WIDTH-1:0] next_write_map_index;

    modport dev (output addr_data, byte_parity, data_error, error, strobes,
        input cpu_coherency_resp, io_coherency_resp, next_read_map_index,
        next_write_map_index);
    modport ctl (input addr_data, byte_parity, data_error, error, strobes,
        output cpu_coherency_resp, io_coherency_resp, next_read_map_index,
        next_write_map_index);
endinterface : sbid_if

// file: hw/sbid_ctl_end.sv
`timescale 1ns/10ps
`include "sbid_defines.svh"
// controller end: presents coherency responses and map indices (R7)-(R10)
module sbid_ctl_end (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    sbid_if.ctl bus,
    input wire logic [7:0] i_cpu_coherency_resp,
    input wire logic [1:0] i_io_coherency_resp,
    input wire logic [`MAP_INDEX_WIDTH-1:0] i_next_read_map_index,
    input wire logic [`MAP_INDEX_WIDTH-1:0] i_next_write_map_index,
    output logic [`DATA_WIDTH-1:0] o_addr_data,
    output logic [`BYTES-1:0] o_byte_parity,
    output logic [1:0] o_data_error,
    output logic o_error,
    output sbid_pkg::strobes_t o_strobes
);
    logic [7:0] cpu_resp;
    logic [1:0] io_resp;
    logic [`MAP_INDEX_WIDTH-1:0] rd_idx;
    logic [`MAP_INDEX_WIDTH-1:0] wr_idx;

    // registered so every field stays 2-bit aligned and reset reads no response
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_resp <= 8'hFF;
            io_resp <= 2'h3;
            rd_idx <= '0;
            wr_idx <= '0;
            o_addr_data <= '0;
            o_byte_parity <= '0;
            o_data_error <= 2'h0;
            o_error <= 1'b0;
            o_strobes <= '0;
        end else begin
            cpu_resp <= i_cpu_coherency_resp; // (R7)
            io_resp <= i_io_coherency_resp; // (R8)
            rd_idx <= i_next_read_map_index; // (R9)
            wr_idx <= i_next_write_map_index; // (R10)
            o_addr_data <= bus.addr_data;
            o_byte_parity <= bus.byte_parity;
            o_data_error <= bus.data_error;
            o_error <= bus.error;
            o_strobes <= bus.strobes;
        end
    end

    assign bus.cpu_coherency_resp = cpu_resp;
    assign bus.io_coherency_resp = io_resp;
    assign bus.next_read_map_index = rd_idx;
    assign bus.next_write_map_index = wr_idx;
endmodule : sbid_ctl_end

// file: hw/sbid_dev_end.sv
`timescale 1ns/10ps
`include "sbid_defines.svh"
// Behaviour
// (R1) upper half error bit1, lower bit0
// (R2) path error sets both error bits
// (R3) path error forces all byte parity high
// (R4) sixteen even byte parity bits forwarded
// (R5) byte parity covers data beats only
// (R6) bus parity error poisons four-byte groups
// (R7) cpu responses in aligned two-bit fields
// (R8) io cache response uses same encoding
// (R9) controller gives next read map index
// (R10) controller gives next write map index
// (R11) dependent, memory, swap, short io decode
// (R12) coherent reads: memory, private, zero-length
// (R13) writes raise memory write, io c2c
// (R14) flush, purge, sync each plus coherent
// (R15) other non-coherent types raise nothing
// (R16) address errors strobe one cycle later
// (R17) data errors only via parity outputs
// (R18) coherent on address-only with type bit2
// (R19) strobes one cycle with address beat
module sbid_dev_end (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    sbid_if.dev bus,
    input wire logic [`DATA_WIDTH-1:0] i_addr_data,
    input wire logic i_addr_valid,
    input wire logic i_data_valid,
    input wire logic [`TT_WIDTH-1:0] i_transaction_type_field,
    input wire logic i_dependent_space,
    input wire logic i_to_io_cache,
    input wire logic i_zero_length_hint,
    input wire logic [`BYTES-1:0] i_bus_byte_parity,
    input wire logic i_addr_error,
    output logic [7:0] o_cpu_coherency_resp,
    output logic [1:0] o_io_coherency_resp,
    output logic [`MAP_INDEX_WIDTH-1:0] o_next_read_map_index,
    output logic [`MAP_INDEX_WIDTH-1:0] o_next_write_map_index
);
    localparam int GROUPS = `BYTES / `GROUP_BYTES;

    function automatic logic tt_is(input logic [`TT_WIDTH-1:0] t,
                                   input logic [`TT_WIDTH-1:0] code);
        tt_is = (t == code);
    endfunction : tt_is

    logic [`TT_WIDTH-1:0] tt;
    assign tt = i_transaction_type_field;

    wire addr_beat = i_addr_valid & ~i_data_valid;
    wire data_beat = i_data_valid & ~i_addr_valid;
    wire path_err = i_addr_valid & i_data_valid;

    // one select per transaction code
    wire is_read = tt_is(tt, `TT_READ);
    wire is_swap_read = tt_is(tt, `TT_BYTE_SWAPPED_READ);
    wire is_read_short = tt_is(tt, `TT_READ_SHORT);
    wire is_write = tt_is(tt, `TT_WRITE);
    wire is_write_back = tt_is(tt, `TT_WRITE_BACK);
    wire is_flush_back = tt_is(tt, `TT_FLUSH_BACK);
    wire is_c2c = tt_is(tt, `TT_CACHE_TO_CACHE_WRITE);
    wire is_write_short = tt_is(tt, `TT_WRITE_SHORT);
    wire is_shared_or_priv = tt_is(tt, `TT_SHARED_OR_PRIVATE_READ);
    wire is_read_current = tt_is(tt, `TT_READ_CURRENT);
    wire is_rd_priv = tt_is(tt, `TT_PRIVATE_READ);
    wire is_clr_priv = tt_is(tt, `TT_CLEAR_PRIVATE);
    wire is_data_flush = tt_is(tt, `TT_DATA_FLUSH);
    wire is_data_flush_wr = tt_is(tt, `TT_DATA_FLUSH_WR);
    wire is_data_flush_rd = tt_is(tt, `TT_DATA_FLUSH_RD);
    wire is_data_flush_rd_wr = tt_is(tt, `TT_DATA_FLUSH_RD_WR);
    wire is_instr_flush = tt_is(tt, `TT_INSTRUCTION_FLUSH);
    wire is_purge = tt_is(tt, `TT_DATA_PURGE);
    wire is_purge_alloc = tt_is(tt, `TT_DATA_PURGE_ALLOCATE);
    wire is_cache_sync = tt_is(tt, `TT_CACHE_SYNC);
    wire is_dma_sync = tt_is(tt, `TT_DMA_SYNC);

    // groups of codes that share a strobe
    wire any_read = is_read | is_swap_read;
    wire coh_read = is_shared_or_priv | is_read_current | is_rd_priv | is_clr_priv;
    wire zero_len = is_rd_priv & i_zero_length_hint;
    wire is_wr = is_write | is_write_back | is_flush_back | is_c2c;
    wire is_flush = is_data_flush | is_data_flush_wr | is_data_flush_rd
                    | is_data_flush_rd_wr | is_instr_flush;
    wire is_sync = is_cache_sync | is_dma_sync;
    wire coherent_type = tt[`TT_COHERENT_BIT];

    sbid_pkg::strobes_t next_strobes;
    always_comb begin
        next_strobes = '0; // (R15)
        if (addr_beat) begin // (R19)
            next_strobes.dependent_read = any_read & i_dependent_space; // (R11)
            next_strobes.mem_read = (any_read & ~i_dependent_space)
                                    | (coh_read & ~zero_len); // (R12)
            next_strobes.byte_swap = is_swap_read; // (R11)
            next_strobes.io_read = is_read_short; // (R11)
            next_strobes.io_write = is_write_short; // (R11)
            next_strobes.private_read = is_rd_priv | is_clr_priv; // (R12)
            next_strobes.zero_length = zero_len; // (R12)
            next_strobes.mem_write = is_wr; // (R13)
            next_strobes.io_cache_to_cache_write = is_c2c & i_to_io_cache; // (R13)
            next_strobes.flush = is_flush; // (R14)
            next_strobes.purge = is_purge; // (R14)
            next_strobes.purge_alloc = is_purge_alloc; // (R14)
            next_strobes.sync = is_sync; // (R14)
            next_strobes.coherent = coherent_type | coh_read; // (R18)
        end
    end

    // per-byte parity check and forwarded even parity
    logic [`BYTES-1:0] calc_par;
    logic [GROUPS-1:0] grp_bad;
    genvar b;
    generate
        for (b = 0; b < `BYTES; b++) begin : g_byte
            assign calc_par[b] = ^i_addr_data[b*8 +: 8]; // (R4)
        end
        for (b = 0; b < GROUPS; b++) begin : g_grp
            assign grp_bad[b] = |(calc_par[b*4 +: 4] ^ i_bus_byte_parity[b*4 +: 4]);
        end
    endgenerate

    // a bad group forwards inverted parity so the consumer sees it as bad
    logic [`BYTES-1:0] poisoned;
    always_comb begin
        poisoned = calc_par;
        for (int g = 0; g < GROUPS; g++) begin
            if (grp_bad[g]) begin
                poisoned[g*4 +: 4] = ~calc_par[g*4 +: 4]; // (R6)
            end
        end
    end

    // a half of the word is bad when any of its groups is
    logic [1:0] half_bad;
    generate
        for (b = 0; b < 2; b++) begin : g_half
            assign half_bad[b] = |grp_bad[b*2 +: 2]; // (R1)
        end
    endgenerate

    // address beats carry no parity; a path error marks every byte
    wire [`BYTES-1:0] next_byte_parity = path_err ? {`BYTES{1'b1}} // (R3)
                                       : (data_beat ? poisoned : '0); // (R5)
    wire [1:0] next_data_error = path_err ? 2'h3 // (R2)
                               : (data_beat ? half_bad : 2'h0); // (R1)

    logic addr_err_pend;
    logic [7:0] cpu_resp;
    logic [1:0] io_resp;
    logic [`DATA_WIDTH-1:0] addr_data;
    logic [`BYTES-1:0] byte_parity;
    logic [1:0] data_error;
    logic error;
    sbid_pkg::strobes_t strobes;

    // bus word and its decode leave together, one cycle after the beat
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_data <= '0;
            strobes <= '0;
            byte_parity <= '0;
            data_error <= 2'h0;
        end else begin
            addr_data <= i_addr_data;
            strobes <= next_strobes; // (R19)
            byte_parity <= next_byte_parity;
            data_error <= next_data_error; // (R17)
        end
    end

    // address errors trail the forwarded address word by one cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_err_pend <= 1'b0;
            error <= 1'b0;
        end else begin
            addr_err_pend <= addr_beat & i_addr_error;
            error <= addr_err_pend; // (R16)
        end
    end

    // coherency responses pass two stages on their way out
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_resp <= `COH_RESP_RESET;
            io_resp <= `IO_RESP_RESET;
            o_cpu_coherency_resp <= `COH_RESP_RESET;
            o_io_coherency_resp <= `IO_RESP_RESET;
        end else begin
            cpu_resp <= bus.cpu_coherency_resp;
            io_resp <= bus.io_coherency_resp;
            o_cpu_coherency_resp <= cpu_resp; // (R7)
            o_io_coherency_resp <= io_resp; // (R8)
        end
    end

    // map indices are already registered at the controller end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_next_read_map_index <= '0;
            o_next_write_map_index <= '0;
        end else begin
            o_next_read_map_index <= bus.next_read_map_index; // (R9)
            o_next_write_map_index <= bus.next_write_map_index; // (R10)
        end
    end

    assign bus.addr_data = addr_data;
    assign bus.strobes = strobes;
    assign bus.byte_parity = byte_parity;
    assign bus.data_error = data_error;
    assign bus.error = error;
endmodule : sbid_dev_end

// file: test/sbid_chk.sv
`timescale 1ns/10ps
`include "sbid_defines.svh"
module sbid_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [`DATA_WIDTH-1:0] addr_data,
    input wire logic [`BYTES-1:0] byte_parity,
    input wire logic [1:0] data_error,
    input wire logic error,
    input wire sbid_pkg::strobes_t strobes
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    function automatic logic [`BYTES-1:0] even_par(input logic [`DATA_WIDTH-1:0] w);
        logic [`BYTES-1:0] p;
        for (int b = 0; b < `BYTES; b++) begin
            p[b] = ^w[8*b+:8];
        end
        return p;
    endfunction : even_par

    AST_ZERO_LEN: assert property (strobes.zero_length |->
        strobes.coherent && strobes.private_read && !strobes.mem_read)
        else $error("zero length read without coherent private");
    AST_COH_KIND: assert property ((strobes.flush || strobes.purge || strobes.purge_alloc
        || strobes.sync) |-> strobes.coherent) else $error("cache op without coherent");
    AST_C2C: assert property (strobes.io_cache_to_cache_write |-> strobes.mem_write)
        else $error("io cache_to_cache_write without memory write");
    AST_SWAP: assert property (strobes.byte_swap |-> strobes.mem_read || strobes.dependent_read)
        else $error("byte swap without a read");
    AST_ONE_CLASS: assert property ($onehot0({strobes.dependent_read, strobes.mem_read,
        strobes.mem_write, strobes.io_read, strobes.io_write, strobes.flush, strobes.purge,
        strobes.purge_alloc, strobes.sync})) else $error("two transaction classes at once");
    AST_ADDR_BEAT: assert property (strobes != '0 |-> byte_parity == '0 && data_error == 2'h0)
        else $error("parity or data error on address beat");
    AST_ERR_AFTER_ADDR: assert property (error |-> $past(data_error) == 2'h0)
        else $error("error strobe after a data error beat");
    AST_LOW_CLEAN: assert property (data_error == 2'h2 |->
        ((byte_parity ^ even_par(addr_data)) & 16'h00FF) == 16'h0000)
        else $error("lower half poisoned");
    AST_HIGH_CLEAN: assert property (data_error == 2'h1 |->
        ((byte_parity ^ even_par(addr_data)) & 16'hFF00) == 16'h0000)
        else $error("upper half poisoned");
    AST_EVEN: assert property (data_error == 2'h0 && strobes == '0 && byte_parity != '0
        |-> byte_parity == even_par(addr_data)) else $error("byte parity not even");
endmodule : sbid_chk

// file: test/system_bus_input_decode_test.sv
`timescale 1ns/10ps
`include "sbid_defines.svh"
module system_bus_input_decode_test;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [127:0] din = '0;
    logic [15:0] bpar = '0;
    logic [6:0] tt = '0;
    logic av = 1'b0, dv = 1'b0, dep = 1'b0, ioc = 1'b0, zl = 1'b0, aerr = 1'b0;
    logic [7:0] cpu = 8'hFF;
    logic [1:0] io = 2'h3;
    logic [4:0] rd = '0, wr = '0;
    logic [7:0] d_cpu;
    logic [1:0] d_io, c_derr;
    logic [4:0] d_rd, d_wr;
    logic [127:0] c_ad;
    logic [15:0] c_par;
    logic c_err;
    sbid_pkg::strobes_t c_strb;
    int num_errors = 0;
    int n_tests = 0;
    localparam logic [6:0] tts [27] = '{7'h00, 7'h00, 7'h01, 7'h01, 7'h04, 7'h05, 7'h06, 7'h06,
        7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0B, 7'h02, 7'h03, 7'h14, 7'h15, 7'h16, 7'h17,
        7'h1C, 7'h24, 7'h25, 7'h2C, 7'h2D, 7'h40, 7'h44};
    localparam logic [2:0] fl [27] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0,
        3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
        3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [13:0] ex [27] = '{14'h2000, 14'h1000, 14'h2004, 14'h1004, 14'h1008,
        14'h1008, 14'h1009, 14'h000B, 14'h1009, 14'h0800, 14'h0800, 14'h0800, 14'h0800,
        14'h0C00, 14'h0200, 14'h0100, 14'h0088, 14'h0088, 14'h0088, 14'h0088, 14'h0088,
        14'h0048, 14'h0028, 14'h0018, 14'h0018, 14'h0000, 14'h0008};

    sbid_if bus ();
    sbid_dev_end i_sbid_dev_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus(bus),
        .i_addr_data(din), .i_addr_valid(av), .i_data_valid(dv), .i_transaction_type_field(tt),
        .i_dependent_space(dep), .i_to_io_cache(ioc), .i_zero_length_hint(zl),
        .i_bus_byte_parity(bpar), .i_addr_error(aerr), .o_cpu_coherency_resp(d_cpu),
        .o_io_coherency_resp(d_io), .o_next_read_map_index(d_rd), .o_next_write_map_index(d_wr));
    sbid_ctl_end i_sbid_ctl_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus(bus),
        .i_cpu_coherency_resp(cpu), .i_io_coherency_resp(io), .i_next_read_map_index(rd),
        .i_next_write_map_index(wr), .o_addr_data(c_ad), .o_byte_parity(c_par),
        .o_data_error(c_derr), .o_error(c_err), .o_strobes(c_strb));
    sbid_chk i_sbid_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .addr_data(bus.addr_data),
        .byte_parity(bus.byte_parity), .data_error(bus.data_error), .error(bus.error),
        .strobes(bus.strobes));

    initial forever #5 i_sys_clk = ~i_sys_clk;

    function automatic logic [15:0] par(input logic [127:0] w);
        logic [15:0] p;
        for (int b = 0; b < 16; b++) begin
            p[b] = ^w[8*b+:8];
        end
        return p;
    endfunction : par

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic step();
        @(posedge i_sys_clk);
        #1;
    endtask : step

    task automatic test_decode();
        for (int i = 0; i < 27; i++) begin
            {av, dv, tt, aerr} = {2'b10, tts[i], i % 3 == 0};
            {dep, ioc, zl} = fl[i];
            din = {16{8'(i)}};
            step();
            {av, aerr} = 2'b00;
            check(bus.strobes === ex[i], "decode strobes");
            check(bus.byte_parity === 16'h0000 && bus.data_error === 2'h0, "addr parity");
            check(c_err === (i > 0 && (i - 1) % 3 == 0), "error forwarded");
            step();
            check(bus.error === (i % 3 == 0), "error strobe timing");
            check(bus.strobes === 14'h0000 && c_strb === ex[i], "strobe span");
        end
        $display("test_decode done");
    endtask : test_decode

    task automatic do_data(input int bad, input logic path);
        logic [15:0] exp;
        logic [1:0] derr;
        din = {32'h0137FE81, 32'h7F00A55A, 32'h12345678, 32'h80010FF0} ^ 128'(bad);
        exp = par(din);
        bpar = exp ^ ((bad >= 0) ? (16'h0001 << bad) : 16'h0000);
        derr = 2'h0;
        if (bad >= 0) begin
            exp[4*(bad/4)+:4] = ~exp[4*(bad/4)+:4];
            derr[bad/8] = 1'b1;
        end
        if (path) begin
            exp = 16'hFFFF;
            derr = 2'h3;
        end
        {av, dv} = {path, 1'b1};
        step();
        {av, dv} = 2'b00;
        check(bus.byte_parity === exp && bus.data_error === derr, "data parity");
        check(bus.strobes === 14'h0000, "strobe on data beat");
        step();
        check(bus.error === 1'b0 && c_par === exp && c_derr === derr, "data error path");
        check(path || c_ad === din, "data word forwarded");
    endtask : do_data

    task automatic test_resp();
        for (int c = 0; c < 4; c++) begin
            cpu = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)};
            io = 2'(3 - c);
            rd = 5'(7 * c + 3);
            wr = 5'(31 - 5 * c);
            step();
            step();
            check(d_rd === 5'(7 * c + 3) && d_wr === 5'(31 - 5 * c), "map index");
            step();
            check(d_cpu === {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)}, "cpu resp");
            check(d_io === 2'(3 - c), "io resp");
        end
        $display("test_resp done");
    endtask : test_resp

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #5000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        repeat (3) @(posedge i_sys_clk);
        #1;
        check(d_cpu === 8'hFF && d_io === 2'h3 && bus.strobes === 14'h0000, "reset values");
        i_rst_n = 1'b1;
        $display("test_reset done");
        test_decode();
        do_data(-1, 1'b0);
        do_data(5, 1'b0);
        do_data(14, 1'b0);
        do_data(3, 1'b1);
        $display("test_data done");
        test_resp();
        conclude();
    end
endmodule : system_bus_input_decode_test
